// [csi_packetizer.sv]
`timescale 1ns/10ps
module csi_packetizer #(
    parameter int PORT_INDEX = 0,
    parameter int AW = 11
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [1:0] virtual_channel_in,
    input wire logic [5:0] long_data_type_in,
    input wire logic link_clk_in,
    input wire logic frame_window_flag_in,
    input wire logic row_window_flag_in,
    input wire logic [7:0] pixel_byte_in,
    input wire logic drop_short_first_line_in,
    output csi_pack_pkg::csi_byte_s csi_byte_out
);
    import csi_pack_pkg::*;

    typedef struct packed {
        logic [7:0] pol;
        logic [7:0] thr;
        logic cfg_tog;
        logic [7:0] rdata;
        logic evt_seen;
        logic wbank;
        logic [AW:0] wcount;
        logic pend_fs;
        logic pend_line;
        logic pend_fe;
        logic [AW:0] pend_len;
        logic pend_bank;
        tx_state_e state;
        logic [1:0] pos;
        logic long_pkt;
        logic go_long;
        logic [5:0] short_dt;
        logic [AW:0] tx_len;
        logic tx_bank;
        logic [AW:0] idx;
        logic [15:0] crc;
        logic [AW:0] rd_addr;
        csi_byte_s out;
    } core_s;

    typedef struct packed {
        link_cfg_s cfg;
        logic cfg_seen;
        logic fv_d;
        logic lv_d;
        logic [8:0] cnt;
        logic first_done;
        logic started;
        logic fwd_row;
        link_evt_e evt_kind;
        logic [7:0] evt_data;
        logic evt_tog;
    } link_s;

    core_s core;
    core_s next_core;
    link_s link;
    link_s next_link;
    link_pins_s pins;
    link_cfg_s cfg_word;
    logic link_rst_n;
    logic cfg_sync;
    logic evt_sync;
    logic mem_we;
    logic [AW:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;

    // Standard CSI-2 header Hamming parity, top two bits zero
    function automatic logic [7:0] ecc_of(input logic [23:0] d);
        logic [7:0] e;
        e = 8'h00;
        for (int i = 0; i < 6; i++) begin
            e[i] = ^(d & ECC_MASKS[i]); // RULE17 RULE22
        end
        return e;
    endfunction

    // Reflected CRC-16, one byte taken LSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1); // RULE18 RULE22
        end
        return r;
    endfunction

    // Pin levels and reset into the link domain
    bit_sync #(.WIDTH($bits(link_pins_s))) pin_sync (
        .clk_in(link_clk_in),
        .level_in({frame_window_flag_in, row_window_flag_in, drop_short_first_line_in,
                   pixel_byte_in}),
        .level_out(pins)
    );
    bit_sync #(.WIDTH(1)) rst_sync (
        .clk_in(link_clk_in),
        .level_in(reset_n_in),
        .level_out(link_rst_n)
    );
    // Config toggle to link, event toggle back to core
    bit_sync #(.WIDTH(1)) cfg_tog_sync (
        .clk_in(link_clk_in),
        .level_in(core.cfg_tog),
        .level_out(cfg_sync)
    );
    bit_sync #(.WIDTH(1)) evt_tog_sync (
        .clk_in(core_clk_in),
        .level_in(link.evt_tog),
        .level_out(evt_sync)
    );

    // Config word stays still while the toggle crosses
    assign cfg_word.fvinv = core.pol[POL_BITS_PER_PORT * PORT_INDEX]; // RULE3
    assign cfg_word.lvinv = core.pol[POL_BITS_PER_PORT * PORT_INDEX + 1]; // RULE3
    assign cfg_word.thr = core.thr;

    // Link side: framing, setup check, first-line policy
    always_comb begin
        logic fv;
        logic lv;
        logic met;
        logic fwd;
        link_evt_e kind;
        next_link = link;
        fv = pins.fv ^ link.cfg.fvinv; // RULE2 RULE3
        lv = pins.lv ^ link.cfg.lvinv; // RULE2 RULE3
        met = link.cnt >= {1'b0, link.cfg.thr}; // RULE4
        fwd = 1'b0;
        kind = EV_NONE;
        if (cfg_sync != link.cfg_seen) begin
            next_link.cfg_seen = cfg_sync;
            next_link.cfg = cfg_word;
        end
        next_link.fv_d = fv;
        next_link.lv_d = lv;
        if (!fv) begin
            // Frame over: close any open row with the frame end
            if (link.fv_d && link.started) begin
                kind = link.fwd_row ? EV_LINE_FE : EV_FE; // RULE1 RULE23
            end
            next_link.started = 1'b0;
            next_link.first_done = 1'b0;
            next_link.fwd_row = 1'b0;
            next_link.cnt = 9'h000;
        end else if (lv && !link.lv_d) begin
            // Short setup only matters for the first row
            fwd = link.first_done || met || pins.fwd; // RULE5 RULE6
            next_link.first_done = 1'b1;
            next_link.fwd_row = fwd;
            if (fwd) begin
                kind = link.started ? EV_BYTE : EV_FS_BYTE; // RULE23
                next_link.started = 1'b1;
            end
        end else if (lv) begin
            if (link.fwd_row) begin
                kind = EV_BYTE; // RULE19
            end
        end else begin
            if (link.fwd_row) begin
                kind = EV_LINE_END; // RULE1
                next_link.fwd_row = 1'b0;
            end else if (!link.first_done && !link.started && met) begin
                kind = EV_FS; // RULE4 RULE23
                next_link.started = 1'b1;
            end
            if (!link.first_done && link.cnt != SETUP_CNT_MAX) begin
                next_link.cnt = link.cnt + 9'h001; // RULE4
            end
        end
        if (kind != EV_NONE) begin
            next_link.evt_kind = kind;
            next_link.evt_data = pins.pix;
            next_link.evt_tog = ~link.evt_tog;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_n) begin
            link <= '0;
            link.cfg.thr <= SETUP_THR_RESET; // RULE8
        end else begin
            link <= next_link;
        end
    end

    // Core side: registers, line banks, packet sender
    always_comb begin
        logic [23:0] hdr;
        logic write_byte;
        logic close_line;
        next_core = core;
        next_core.out = '0;
        mem_we = 1'b0;
        mem_waddr = {core.wbank, core.wcount[AW-1:0]};
        mem_wdata = link.evt_data;
        write_byte = 1'b0;
        close_line = 1'b0;
        if (core.long_pkt) begin
            hdr = {16'(core.tx_len), virtual_channel_in, long_data_type_in}; // RULE15 RULE16
        end else begin
            hdr = {16'h0000, virtual_channel_in, core.short_dt}; // RULE11 RULE13 RULE20
        end
        // Register writes; a write to the polarity or setup register re-sends config to the link
        if (reg_write_in) begin
            if (reg_addr_in == OFF_POLARITY) begin
                next_core.pol = reg_wdata_in;
                next_core.cfg_tog = ~core.cfg_tog;
            end else if (reg_addr_in == OFF_SETUP_THR) begin
                next_core.thr = reg_wdata_in;
                next_core.cfg_tog = ~core.cfg_tog;
            end
        end
        if (reg_addr_in == OFF_POLARITY) begin
            next_core.rdata = core.pol;
        end else if (reg_addr_in == OFF_SETUP_THR) begin
            next_core.rdata = core.thr;
        end else begin
            next_core.rdata = 8'h00;
        end
        // Packet sender, one byte per clock
        case (core.state)
            ST_IDLE: begin
                next_core.pos = 2'h0;
                next_core.long_pkt = 1'b0;
                next_core.go_long = 1'b0;
                if (core.pend_fs) begin
                    next_core.pend_fs = 1'b0;
                    next_core.short_dt = DT_FRAME_START; // RULE12
                    next_core.state = ST_HEAD;
                end else if (core.pend_line) begin
                    next_core.pend_line = 1'b0;
                    next_core.tx_len = core.pend_len;
                    next_core.tx_bank = core.pend_bank;
                    next_core.short_dt = DT_LINE_START; // RULE12
                    next_core.go_long = 1'b1;
                    next_core.state = ST_HEAD;
                end else if (core.pend_fe) begin
                    next_core.pend_fe = 1'b0;
                    next_core.short_dt = DT_FRAME_END; // RULE12
                    next_core.state = ST_HEAD;
                end
            end
            ST_HEAD: begin
                next_core.out.valid = 1'b1;
                next_core.pos = core.pos + 2'h1;
                if (core.pos == 2'h0) begin
                    next_core.out.start = 1'b1;
                    next_core.out.data = hdr[7:0]; // RULE21
                end else if (core.pos == 2'h1) begin
                    next_core.out.data = hdr[15:8];
                end else if (core.pos == 2'h2) begin
                    next_core.out.data = hdr[23:16];
                end else begin
                    next_core.out.data = ecc_of(hdr); // RULE17
                    next_core.out.stop = !core.long_pkt; // RULE13
                end
                if (core.pos == HEAD_LAST) begin
                    next_core.pos = 2'h0;
                    if (core.long_pkt) begin
                        next_core.crc = CRC_SEED;
                        next_core.idx = '0;
                        next_core.rd_addr = {core.tx_bank, {AW{1'b0}}};
                        next_core.state = (core.tx_len == '0) ? ST_TAIL : ST_DATA; // RULE14
                    end else if (core.go_long) begin
                        next_core.long_pkt = 1'b1; // RULE9
                        next_core.go_long = 1'b0;
                    end else begin
                        next_core.state = ST_IDLE;
                    end
                end
            end
            ST_DATA: begin
                // Memory data arrive one cycle after the address
                next_core.out.valid = 1'b1;
                next_core.out.data = mem_rdata; // RULE10 RULE19
                next_core.crc = crc_byte(core.crc, mem_rdata); // RULE18
                next_core.idx = core.idx + 1'b1;
                next_core.rd_addr = {core.tx_bank, AW'(core.idx + 1'b1)};
                if (core.idx == core.tx_len - 1'b1) begin
                    next_core.state = ST_TAIL; // RULE16
                end
            end
            default: begin
                next_core.out.valid = 1'b1;
                next_core.pos = core.pos + 2'h1;
                if (core.pos == 2'h0) begin
                    next_core.out.data = core.crc[7:0]; // RULE14 RULE18
                end else begin
                    next_core.out.data = core.crc[15:8];
                    next_core.out.stop = 1'b1;
                end
                if (core.pos == TAIL_LAST) begin
                    // Line end short packet follows straight on
                    next_core.pos = 2'h0;
                    next_core.long_pkt = 1'b0;
                    next_core.short_dt = DT_LINE_END; // RULE12
                    next_core.state = ST_HEAD;
                end
            end
        endcase
        // Link events after the sender, so a new set beats a clear
        if (evt_sync != core.evt_seen) begin
            next_core.evt_seen = evt_sync;
            case (link.evt_kind)
                EV_FS: begin
                    next_core.pend_fs = 1'b1; // RULE23
                end
                EV_FS_BYTE: begin
                    next_core.pend_fs = 1'b1;
                    write_byte = 1'b1;
                end
                EV_BYTE: begin
                    write_byte = 1'b1;
                end
                EV_LINE_END: begin
                    close_line = 1'b1;
                end
                EV_FE: begin
                    next_core.pend_fe = 1'b1; // RULE23
                end
                EV_LINE_FE: begin
                    close_line = 1'b1;
                    next_core.pend_fe = 1'b1;
                end
                default: begin
                    write_byte = 1'b0;
                end
            endcase
        end
        // Bytes beyond one bank are lost; the line is sent truncated
        if (write_byte && !core.wcount[AW]) begin
            mem_we = 1'b1;
            next_core.wcount = core.wcount + 1'b1;
        end
        // Ping-pong banks let the next row fill while this one sends
        if (close_line) begin
            next_core.pend_line = 1'b1;
            next_core.pend_len = core.wcount;
            next_core.pend_bank = core.wbank;
            next_core.wbank = ~core.wbank;
            next_core.wcount = '0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            core <= '0;
            core.pol <= POLARITY_RESET;
            core.thr <= SETUP_THR_RESET; // RULE8
            core.state <= ST_IDLE;
            core.crc <= CRC_SEED;
        end else begin
            core <= next_core;
        end
    end

    line_memory #(.ADDR_WIDTH(AW + 1), .DATA_WIDTH(8)) bank_mem (
        .clk_in(core_clk_in),
        .write_in(mem_we),
        .write_addr_in(mem_waddr),
        .write_data_in(mem_wdata),
        .read_addr_in(next_core.rd_addr),
        .read_data_out(mem_rdata)
    );

    assign csi_byte_out = core.out;
    assign reg_rdata_out = core.rdata;

    // Checking aids: byte position, last three bytes, word count
    logic [16:0] chk_pos;
    logic [23:0] chk_hist;
    logic [15:0] chk_wc;
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            chk_pos <= 17'h00000;
            chk_hist <= 24'h000000;
            chk_wc <= 16'h0000;
        end else if (core.out.valid) begin
            chk_pos <= core.out.start ? 17'h00001 : chk_pos + 17'h00001;
            chk_hist <= {core.out.data, chk_hist[23:8]};
            if (chk_pos == 17'h00003 && !core.out.start) begin
                chk_wc <= chk_hist[23:8];
            end
        end
    end

    a_ident_channel: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE21
        core.out.valid && core.out.start |-> core.out.data[7:6] == $past(virtual_channel_in))
        else $error("identifier channel bits wrong");
    a_short_length: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE13
        core.out.valid && core.out.start && core.out.data[5:0] < SHORT_DT_LIMIT
        |-> ##3 core.out.valid && core.out.stop)
        else $error("short packet not four bytes");
    a_long_head_run: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE14
        core.out.valid && core.out.start && core.out.data[5:0] >= SHORT_DT_LIMIT
        |=> (core.out.valid && !core.out.stop) [*3])
        else $error("long header broken");
    a_header_ecc: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE17
        core.out.valid && !core.out.start && chk_pos == 17'h00003
        |-> core.out.data == ecc_of(chk_hist))
        else $error("header ECC mismatch");
    a_count_matches: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE16
        core.out.valid && core.out.stop && chk_pos > 17'h00003
        |-> chk_pos == {1'b0, chk_wc} + 17'h00005)
        else $error("word count and payload differ");
    a_line_end_follows: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE12
        core.out.valid && core.out.stop && chk_pos > 17'h00003
        |=> core.out.start && core.out.data[5:0] == DT_LINE_END)
        else $error("no line end after long packet");
    a_thr_reset: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // RULE8
        $rose(reset_n_in) |-> core.thr == SETUP_THR_RESET && reg_rdata_out == 8'h00)
        else $error("threshold reset value wrong");
    a_fs_needs_setup: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // RULE4
        next_link.evt_tog != link.evt_tog && next_link.evt_kind == EV_FS
        |-> link.cnt >= {1'b0, link.cfg.thr})
        else $error("frame start before setup met");
    a_drop_first: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // RULE5
        !link.first_done && !next_link.fwd_row && next_link.first_done
        |-> link.cnt < {1'b0, link.cfg.thr} && !pins.fwd)
        else $error("first line dropped wrongly");
    a_fwd_short: assert property (@(posedge link_clk_in) disable iff (!link_rst_n) // RULE6
        pins.fwd && !link.first_done && next_link.first_done |=> link.fwd_row)
        else $error("short first line not forwarded");
endmodule

// [csi_pack_pkg.sv]
// What this block does
// RULE1: Derive frame and line boundaries from port input
// RULE2: Frame flag is vertical sync, row flag horizontal
// RULE3: Per-port independent frame and row polarity bits
// RULE4: Frame valid only after programmable setup clocks
// RULE5: Drop first line when setup not met
// RULE6: Control bit forwards short first line instead
// RULE7: Source holds frame flag ahead of row flag
// RULE8: Setup threshold resets to 128
// RULE9: Send short and long packet formats
// RULE10: Payload is arbitrary bytes, 8-bit words
// RULE11: Up to four virtual channels per link
// RULE12: Frame start, frame end, line start, line end packets
// RULE13: Short packets 32 bits, data type below 0x10
// RULE14: Long packet: header, payload bytes, 16-bit footer
// RULE15: Header: identifier, word count, ECC in order
// RULE16: Word count equals payload byte count
// RULE17: ECC covers identifier and word count
// RULE18: Footer carries CRC over payload bytes
// RULE19: Payload bytes pass unchanged
// RULE20: Identifier holds channel and data type
// RULE21: Channel in two top bits, type below
// RULE22: Standard Hamming ECC and CRC-16 polynomial
// RULE23: Raw port emits frame start, lines, frame end
package csi_pack_pkg;
    localparam logic [7:0] OFF_POLARITY = 8'h7c;
    localparam logic [7:0] OFF_SETUP_THR = 8'hbc;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic [7:0] SETUP_THR_RESET = 8'h80;
    localparam int POL_BITS_PER_PORT = 2;
    localparam logic [8:0] SETUP_CNT_MAX = 9'h1ff;
    localparam logic [5:0] DT_FRAME_START = 6'h00;
    localparam logic [5:0] DT_FRAME_END = 6'h01;
    localparam logic [5:0] DT_LINE_START = 6'h02;
    localparam logic [5:0] DT_LINE_END = 6'h03;
    localparam logic [5:0] SHORT_DT_LIMIT = 6'h10;
    localparam logic [1:0] HEAD_LAST = 2'h3;
    localparam logic [1:0] TAIL_LAST = 2'h1;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    // Parity masks over {word count, identifier}, bit 5 listed first
    localparam logic [5:0][23:0] ECC_MASKS = {24'heffc00, 24'hdf03f0, 24'hb8e38e,
                                              24'h749a6d, 24'hf2555b, 24'hf12cb7};

    typedef enum logic [2:0] {
        EV_NONE = 3'h0,
        EV_FS = 3'h1,
        EV_FS_BYTE = 3'h2,
        EV_BYTE = 3'h3,
        EV_LINE_END = 3'h4,
        EV_FE = 3'h5,
        EV_LINE_FE = 3'h6
    } link_evt_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HEAD = 2'h1,
        ST_DATA = 2'h2,
        ST_TAIL = 2'h3
    } tx_state_e;

    typedef struct packed {
        logic valid;
        logic start;
        logic stop;
        logic [7:0] data;
    } csi_byte_s;

    typedef struct packed {
        logic fv;
        logic lv;
        logic fwd;
        logic [7:0] pix;
    } link_pins_s;

    typedef struct packed {
        logic fvinv;
        logic lvinv;
        logic [7:0] thr;
    } link_cfg_s;
endpackage

// [bit_sync.sv]
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;
    sync_s st;
    sync_s next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.first = level_in;
        next_st.second = st.first;
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign level_out = st.second;
endmodule

// [line_memory.sv]
`timescale 1ns/10ps
module line_memory #(
    parameter int ADDR_WIDTH = 12,
    parameter int DATA_WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic write_in,
    input wire logic [ADDR_WIDTH-1:0] write_addr_in,
    input wire logic [DATA_WIDTH-1:0] write_data_in,
    input wire logic [ADDR_WIDTH-1:0] read_addr_in,
    output logic [DATA_WIDTH-1:0] read_data_out
);
    logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

    // Registered read, one cycle after the address
    always_ff @(posedge clk_in) begin
        if (write_in) begin
            mem[write_addr_in] <= write_data_in;
        end
        read_data_out <= mem[read_addr_in];
    end
endmodule

// [csi_rx_model.sv]
`timescale 1ns/10ps
// Receiver side of the byte stream: takes every byte and cannot stall
module csi_rx_model (
    input wire logic core_clk_in,
    input wire csi_pack_pkg::csi_byte_s csi_byte_in
);
    import csi_pack_pkg::*;
    logic [9:0] got[$];
    // Keep start and stop marks with each byte so packet framing is checked too
    // Falling edge: the registered byte has settled half a cycle earlier
    always @(negedge core_clk_in) begin
        if (csi_byte_in.valid === 1'b1) begin
            got.push_back({csi_byte_in.start, csi_byte_in.stop, csi_byte_in.data});
        end
    end
endmodule

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
    import csi_pack_pkg::*;
    logic core_clk = 0, link_clk = 0, rst_n = 0, wr_en = 0, fv = 0, lv = 1, fwd = 0, rinv = 1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pix = 8'h00, rdata;
    logic [1:0] vc = 2'h2;
    logic finv = 0;
    csi_byte_s csi;
    logic [9:0] exp[$];
    int fail_count = 0, checks = 0;
    localparam logic [5:0] LDT = 6'h2b;
    // Clocks; the link clock starts off phase so edges never line up
    always #10 core_clk = ~core_clk;
    always begin
        if ($time == 0) #3;
        #80 link_clk = ~link_clk;
    end
    csi_packetizer #(.PORT_INDEX(0), .AW(4)) u_csi_packetizer (.core_clk_in(core_clk),
        .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en),
        .reg_rdata_out(rdata), .virtual_channel_in(vc), .long_data_type_in(LDT),
        .link_clk_in(link_clk), .frame_window_flag_in(fv), .row_window_flag_in(lv),
        .pixel_byte_in(pix), .drop_short_first_line_in(fwd), .csi_byte_out(csi));
    csi_rx_model u_csi_rx_model (.core_clk_in(core_clk), .csi_byte_in(csi));

    task automatic cmp(string what, logic [9:0] e, logic [9:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        wdata = d;
        wr_en = 1;
        @(negedge core_clk);
        wr_en = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge core_clk);
        addr = a;
        @(negedge core_clk);
        cmp("reg_rdata", {2'b00, e}, {2'b00, rdata});
    endtask
    // Header bytes, identifier first; a short packet ends on its ECC byte
    task automatic put_hdr(logic [5:0] dt, logic [15:0] wc, bit lng);
        logic [23:0] h;
        logic [7:0] e;
        h = {wc, vc, dt};
        e = 8'h00;
        for (int i = 0; i < 6; i++) e[i] = ^(h & ECC_MASKS[i]);
        exp.push_back({2'b10, h[7:0]});
        exp.push_back({2'b00, wc[7:0]});
        exp.push_back({2'b00, wc[15:8]});
        exp.push_back({1'b0, !lng, e});
    endtask
    // Line start, long packet with reflected CRC over payload, line end
    task automatic put_line(int n, logic [7:0] base);
        logic [15:0] crc;
        logic [7:0] b;
        crc = CRC_SEED;
        put_hdr(DT_LINE_START, 16'h0000, 0);
        put_hdr(LDT, 16'(n), 1);
        for (int j = 0; j < n; j++) begin
            b = base + 8'(j);
            exp.push_back({2'b00, b});
            for (int k = 0; k < 8; k++) crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? CRC_POLY : 16'h0);
        end
        exp.push_back({2'b00, crc[7:0]});
        exp.push_back({2'b01, crc[15:8]});
        put_hdr(DT_LINE_END, 16'h0000, 0);
    endtask
    // Two rows; row r carries bytes from fe plus 16*r; idle data is inverted, not held
    task automatic frame(int setup, int n0, int n1);
        int n[2];
        n = '{n0, n1};
        @(negedge link_clk);
        fv = ~finv;
        repeat (setup) @(negedge link_clk);
        for (int r = 0; r < 2; r++) begin
            for (int j = 0; j < n[r]; j++) begin
                lv = ~rinv;
                pix = 8'hfe + 8'(16 * r + j);
                @(negedge link_clk);
            end
            lv = rinv;
            pix = ~pix;
            repeat (3) @(negedge link_clk);
        end
        fv = finv;
        repeat (4) @(negedge link_clk);
        repeat (80) @(negedge core_clk);
    endtask
    task automatic check_frame(string what);
        cmp({what, "_len"}, 10'(exp.size()), 10'(u_csi_rx_model.got.size()));
        while (exp.size() > 0 && u_csi_rx_model.got.size() > 0) begin
            cmp(what, exp.pop_front(), u_csi_rx_model.got.pop_front());
        end
        exp.delete();
        u_csi_rx_model.got.delete();
    endtask
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence; reset spans four link edges so the link side clears too
    initial begin
        repeat (4) @(posedge link_clk);
        @(negedge core_clk);
        rst_n = 1;
        repeat (4) @(posedge link_clk);
        rd(OFF_POLARITY, 8'h00);
        rd(OFF_SETUP_THR, 8'h80);
        rd(8'h7d, 8'h00);
        wr(OFF_SETUP_THR, 8'h02);
        wr(OFF_POLARITY, 8'h02);
        rd(OFF_POLARITY, 8'h02);
        repeat (6) @(negedge link_clk);
        put_hdr(DT_FRAME_START, 16'h0000, 0);
        put_line(4, 8'hfe);
        put_line(2, 8'h0e);
        put_hdr(DT_FRAME_END, 16'h0000, 0);
        frame(6, 4, 2);
        check_frame("frame_setup_met");
        wr(OFF_SETUP_THR, 8'h10);
        vc = 2'h1;
        put_hdr(DT_FRAME_START, 16'h0000, 0);
        put_line(2, 8'h0e);
        put_hdr(DT_FRAME_END, 16'h0000, 0);
        frame(1, 3, 2);
        check_frame("first_row_dropped");
        fwd = 1;
        vc = 2'h3;
        // Frame flag idles high from here on; the brief false frame stays below threshold
        finv = 1;
        fv = 1;
        wr(OFF_POLARITY, 8'h03);
        rd(OFF_POLARITY, 8'h03);
        repeat (6) @(negedge link_clk);
        put_hdr(DT_FRAME_START, 16'h0000, 0);
        put_line(3, 8'hfe);
        put_line(2, 8'h0e);
        put_hdr(DT_FRAME_END, 16'h0000, 0);
        frame(1, 3, 2);
        check_frame("first_row_kept");
        end_sim;
    end
    // Watchdog well beyond the roughly 17 microseconds the sequence needs
    initial begin
        #200us;
        fail_count++;
        end_sim;
    end
endmodule
